// ===== hdl/usbhfe_host_regs.v
/*
 * Host side register logic of two host instances, the second without OTG events: count
 * difference of the last received packet, target device address, event
 * flags with enables, frame timer and next frame number.
 * Assumes a synchronous 16-bit register port (one-cycle read and write
 * strobes) and event inputs already synchronous to the core clock.
 */
`timescale 1ns/10ps
`include "usbhfe_map.vh"

module usbhfe_host_regs (
   input wire clock,
   input wire reset_n,
   input wire [15:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata_q,
   output reg reg_rvalid_q,
   input wire vbus_above_threshold,
   input wire otg_id_level,
   input wire [1:0] line_single_ended_zero_state,
   input wire [1:0] remote_wake,
   input wire [1:0] transfer_done,
   input wire [1:0] sof_sent,
   input wire [1:0] rx_packet_done,
   input wire [10:0] rx_length_h1,
   input wire [10:0] rx_length_h2,
   input wire [9:0] transfer_count_h1,
   input wire [9:0] transfer_count_h2,
   output reg [6:0] target_addr_h1_q,
   output reg [6:0] target_addr_h2_q,
   output reg [1:0] length_exception_q,
   output reg [1:0] overflow_q,
   output reg [1:0] underflow_q,
   output reg [1:0] sof_due_q,
   output reg [1:0] host_irq_q
);

   localparam SEL_RESULT = 3'd0;
   localparam SEL_ENABLE = 3'd1;
   localparam SEL_STATUS = 3'd2;
   localparam SEL_RELOAD = 3'd3;
   localparam SEL_LIVE = 3'd4;
   localparam SEL_FRAME = 3'd5;

   // per instance storage, index 0 is the first host
   reg [15:0] count_diff_q [0:1];
   reg [15:0] enable_q [0:1];
   reg [15:0] flags_q [0:1];
   reg [13:0] reload_q [0:1];
   reg [10:0] frame_q [0:1];
   reg [1:0] se0_q;
   reg [1:0] se0_prev_q;
   reg vbus_q;
   reg vbus_prev_q;
   reg id_q;
   reg id_prev_q;
   reg armed_q;
   wire [13:0] live_count [0:1];
   wire [1:0] expire;
   wire [4:0] dec;
   wire hit;
   wire inst;
   wire [2:0] sel;
   reg [15:0] event_set [0:1];
   reg [15:0] rdata_d;
   integer i;

   // address decode: bit 4 hit, bit 3 instance, bits 2:0 register select
   function [4:0] decode;
      input [15:0] addr;
      begin
         case (addr)
            `USBHFE_H1_COUNT_DIFF: decode = {1'b1, 1'b0, SEL_RESULT};
            `USBHFE_H1_EVENT_ENABLE: decode = {1'b1, 1'b0, SEL_ENABLE};
            `USBHFE_H1_EVENT_STATUS: decode = {1'b1, 1'b0, SEL_STATUS};
            `USBHFE_H1_FRAME_RELOAD: decode = {1'b1, 1'b0, SEL_RELOAD};
            `USBHFE_H1_FRAME_LIVE: decode = {1'b1, 1'b0, SEL_LIVE};
            `USBHFE_H1_NEXT_FRAME: decode = {1'b1, 1'b0, SEL_FRAME};
            `USBHFE_H2_COUNT_DIFF: decode = {1'b1, 1'b1, SEL_RESULT};
            `USBHFE_H2_EVENT_ENABLE: decode = {1'b1, 1'b1, SEL_ENABLE};
            `USBHFE_H2_EVENT_STATUS: decode = {1'b1, 1'b1, SEL_STATUS};
            `USBHFE_H2_FRAME_RELOAD: decode = {1'b1, 1'b1, SEL_RELOAD};
            `USBHFE_H2_FRAME_LIVE: decode = {1'b1, 1'b1, SEL_LIVE};
            `USBHFE_H2_NEXT_FRAME: decode = {1'b1, 1'b1, SEL_FRAME};
            default: decode = 5'h00;
         endcase
      end
   endfunction

   // implemented event bits of an instance; the second has no OTG bits
   function [15:0] event_mask;
      input idx;
      begin
         event_mask = idx ? `USBHFE_H2_EVENT_MASK : `USBHFE_H1_EVENT_MASK;
      end
   endfunction

   // count difference: programmed count minus received length
   function [15:0] count_diff;
      input [9:0] prog;
      input [10:0] rxlen;
      reg [15:0] diff;
      begin
         diff = {6'h00, prog} - {5'h00, rxlen};
         if ({1'b0, prog} < rxlen)
            diff[15:10] = `USBHFE_OVF_FORCE;
         count_diff = diff;
      end
   endfunction

   assign dec = decode(reg_addr);
   assign hit = dec[4];
   assign inst = dec[3];
   assign sel = dec[2:0];

   usbhfe_frame_timer u_timer_h1 (
      .clock(clock),
      .reset_n(reset_n),
      .reload_value(reload_q[0]),
      .count_q(live_count[0]),
      .expire_q(expire[0])
   );

   usbhfe_frame_timer u_timer_h2 (
      .clock(clock),
      .reset_n(reset_n),
      .reload_value(reload_q[1]),
      .count_q(live_count[1]),
      .expire_q(expire[1])
   );

   // sampled line levels for edge detection; reset loads both stages with the
   // live level, so a level already high at reset never looks like an edge
   always @(posedge clock) begin
      if (!reset_n) begin
         se0_q <= line_single_ended_zero_state;
         se0_prev_q <= line_single_ended_zero_state;
         vbus_q <= vbus_above_threshold;
         vbus_prev_q <= vbus_above_threshold;
         id_q <= otg_id_level;
         id_prev_q <= otg_id_level;
         armed_q <= 1'b0;
      end else begin
         se0_q <= line_single_ended_zero_state;
         se0_prev_q <= se0_q;
         vbus_q <= vbus_above_threshold;
         vbus_prev_q <= vbus_q;
         id_q <= otg_id_level;
         id_prev_q <= id_q;
         armed_q <= 1'b1;
      end
   end

   // hardware events per instance, one-cycle set requests
   always @* begin
      for (i = 0; i < 2; i = i + 1) begin
         event_set[i] = 16'h0000;
         event_set[i][`USBHFE_BIT_FRAME] = expire[i];
         event_set[i][`USBHFE_BIT_WAKE] = remote_wake[i];
         event_set[i][`USBHFE_BIT_CONN] = armed_q && (se0_q[i] != se0_prev_q[i]);
         event_set[i][`USBHFE_BIT_DONE] = transfer_done[i];
      end
      event_set[0][`USBHFE_BIT_VBUS] = armed_q && (vbus_q != vbus_prev_q);
      event_set[0][`USBHFE_BIT_ID] = armed_q && (id_q != id_prev_q);
   end

   // event flags: sticky, set wins over a same-cycle clear
   always @(posedge clock) begin
      if (!reset_n) begin
         flags_q[0] <= 16'h0000;
         flags_q[1] <= 16'h0000;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            if (reg_wr && hit && sel == SEL_STATUS && inst == i[0])
               flags_q[i] <= ((flags_q[i] & ~reg_wdata) | event_set[i]) & event_mask(i[0]);
            else
               flags_q[i] <= (flags_q[i] | event_set[i]) & event_mask(i[0]);
         end
      end
   end

   // event enables; unimplemented bits stay zero
   always @(posedge clock) begin
      if (!reset_n) begin
         enable_q[0] <= 16'h0000;
         enable_q[1] <= 16'h0000;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            if (reg_wr && hit && sel == SEL_ENABLE && inst == i[0])
               enable_q[i] <= reg_wdata & event_mask(i[0]);
         end
      end
   end

   // interrupt request per instance, registered
   always @(posedge clock) begin
      if (!reset_n) begin
         host_irq_q <= 2'b00;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            host_irq_q[i] <= |(flags_q[i] & enable_q[i]);
         end
      end
   end

   // target device address, write-only at the count difference offset
   always @(posedge clock) begin
      if (!reset_n) begin
         target_addr_h1_q <= `USBHFE_ADDR_RESET;
         target_addr_h2_q <= `USBHFE_ADDR_RESET;
      end else if (reg_wr && hit && sel == SEL_RESULT) begin
         if (inst)
            target_addr_h2_q <= reg_wdata[6:0];
         else
            target_addr_h1_q <= reg_wdata[6:0];
      end
   end

   // received packet length check, updated once per received packet
   always @(posedge clock) begin
      if (!reset_n) begin
         count_diff_q[0] <= 16'h0000;
         count_diff_q[1] <= 16'h0000;
         length_exception_q <= 2'b00;
         overflow_q <= 2'b00;
         underflow_q <= 2'b00;
      end else begin
         if (rx_packet_done[0]) begin
            count_diff_q[0] <= count_diff(transfer_count_h1, rx_length_h1);
            length_exception_q[0] <= {1'b0, transfer_count_h1} != rx_length_h1;
            overflow_q[0] <= {1'b0, transfer_count_h1} < rx_length_h1;
            underflow_q[0] <= {1'b0, transfer_count_h1} > rx_length_h1;
         end
         if (rx_packet_done[1]) begin
            count_diff_q[1] <= count_diff(transfer_count_h2, rx_length_h2);
            length_exception_q[1] <= {1'b0, transfer_count_h2} != rx_length_h2;
            overflow_q[1] <= {1'b0, transfer_count_h2} < rx_length_h2;
            underflow_q[1] <= {1'b0, transfer_count_h2} > rx_length_h2;
         end
      end
   end

   // frame reload value and next frame number
   always @(posedge clock) begin
      if (!reset_n) begin
         reload_q[0] <= `USBHFE_RELOAD_RESET;
         reload_q[1] <= `USBHFE_RELOAD_RESET;
         frame_q[0] <= `USBHFE_FRAME_RESET;
         frame_q[1] <= `USBHFE_FRAME_RESET;
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            if (reg_wr && hit && sel == SEL_RELOAD && inst == i[0]) begin
               reload_q[i] <= reg_wdata[13:0];
               frame_q[i] <= `USBHFE_FRAME_RESET;
            end else if (sof_sent[i]) begin
               frame_q[i] <= frame_q[i] + 11'h001;
            end
         end
      end
   end

   // frame start request toward the transmitter follows timer expiry
   always @(posedge clock) begin
      if (!reset_n)
         sof_due_q <= 2'b00;
      else
         sof_due_q <= expire;
   end

   // read data select; unmapped addresses read zero
   always @* begin
      rdata_d = 16'h0000;
      if (hit) begin
         case (sel)
            SEL_RESULT: rdata_d = count_diff_q[inst];
            SEL_ENABLE: rdata_d = enable_q[inst];
            SEL_STATUS: begin
               rdata_d = flags_q[inst];
               rdata_d[`USBHFE_BIT_SE0] = se0_q[inst];
            end
            SEL_RELOAD: rdata_d = {2'b00, reload_q[inst]};
            SEL_LIVE: rdata_d = {2'b00, live_count[inst]};
            SEL_FRAME: rdata_d = {5'h00, frame_q[inst]};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   // read answer registered one cycle after the strobe
   always @(posedge clock) begin
      if (!reset_n) begin
         reg_rdata_q <= 16'h0000;
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd)
            reg_rdata_q <= rdata_d;
      end
   end

endmodule

// ===== shared/usbhfe_map.vh
/*
 * Constants of the dual host frame and event logic: register offsets,
 * field positions, reset values and frame timing counts.
 * Assumes a 16-bit register port with full byte addresses and a 100 MHz core clock.
 */
`ifndef USBHFE_MAP_VH
`define USBHFE_MAP_VH

// register byte addresses, first host instance
`define USBHFE_H1_COUNT_DIFF 16'hC088
`define USBHFE_H1_TARGET_ADDR 16'hC088
`define USBHFE_H1_EVENT_ENABLE 16'hC08C
`define USBHFE_H1_EVENT_STATUS 16'hC090
`define USBHFE_H1_FRAME_RELOAD 16'hC092
`define USBHFE_H1_FRAME_LIVE 16'hC094
`define USBHFE_H1_NEXT_FRAME 16'hC096
// register byte addresses, second host instance
`define USBHFE_H2_COUNT_DIFF 16'hC0A8
`define USBHFE_H2_TARGET_ADDR 16'hC0A8
`define USBHFE_H2_EVENT_ENABLE 16'hC0AC
`define USBHFE_H2_EVENT_STATUS 16'hC0B0
`define USBHFE_H2_FRAME_RELOAD 16'hC0B2
`define USBHFE_H2_FRAME_LIVE 16'hC0B4
`define USBHFE_H2_NEXT_FRAME 16'hC0B6

// event enable and status bit positions
`define USBHFE_BIT_VBUS 15
`define USBHFE_BIT_ID 14
`define USBHFE_BIT_FRAME 9
`define USBHFE_BIT_WAKE 6
`define USBHFE_BIT_CONN 4
`define USBHFE_BIT_SE0 2
`define USBHFE_BIT_DONE 0

// implemented enable and flag bits per instance
`define USBHFE_H1_EVENT_MASK 16'hC251
`define USBHFE_H2_EVENT_MASK 16'h0251

// count difference forcing on overflow
`define USBHFE_OVF_FORCE 6'h3F

// reset values
`define USBHFE_RELOAD_RESET 14'h2EE0
`define USBHFE_FRAME_RESET 11'h000
`define USBHFE_ADDR_RESET 7'h00

// frame timer rate: core clock and timer tick, both in MHz
`define USBHFE_CORE_MHZ 7'd100
`define USBHFE_TICK_MHZ 7'd12

`endif

// ===== hdl/usbhfe_frame_timer.v
/*
 * Frame down counter of one host instance, with its own 12 MHz tick
 * drawn from the core clock by a fractional accumulator.
 * Assumes the reload value is held stable by the register logic around it.
 */
`timescale 1ns/10ps
`include "usbhfe_map.vh"

module usbhfe_frame_timer (
   input wire clock,
   input wire reset_n,
   input wire [13:0] reload_value,
   output reg [13:0] count_q,
   output reg expire_q
);

   reg [6:0] acc_q;
   reg [6:0] acc_d;
   reg tick_d;
   reg [13:0] count_d;

   // tick generator: adds the tick rate each core cycle, wraps at the core rate;
   // jitter of one core cycle per tick is traded for not needing a 12 MHz clock
   always @* begin
      acc_d = acc_q + `USBHFE_TICK_MHZ;
      tick_d = 1'b0;
      if (acc_d >= `USBHFE_CORE_MHZ) begin
         acc_d = acc_d - `USBHFE_CORE_MHZ;
         tick_d = 1'b1;
      end
   end

   // down counter next value
   always @* begin
      count_d = count_q;
      if (tick_d) begin
         if (count_q == 14'h0000)
            count_d = reload_value;
         else
            count_d = count_q - 14'h0001;
      end
   end

   // counter, accumulator and expiry pulse
   always @(posedge clock) begin
      if (!reset_n) begin
         acc_q <= 7'h00;
         count_q <= `USBHFE_RELOAD_RESET;
         expire_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         count_q <= count_d;
         expire_q <= tick_d && (count_q == 14'h0000);
      end
   end

endmodule

// ===== tb/usbhfe_chk_assertions.sv
/* checker of the dual host register block: length flags, target address,
   reload and frame number reads, enable masking, frame pulse spacing.
   assumes it is bound to usbhfe_host_regs and sees only its ports. */
`timescale 1ns/10ps
`include "usbhfe_map.vh"
module usbhfe_chk (
   input wire clock,
   input wire reset_n,
   input wire [15:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_wdata,
   input wire [15:0] reg_rdata_q,
   input wire [1:0] rx_packet_done,
   input wire [10:0] rx_length_h1,
   input wire [10:0] rx_length_h2,
   input wire [9:0] transfer_count_h1,
   input wire [9:0] transfer_count_h2,
   input wire [6:0] target_addr_h1_q,
   input wire [1:0] length_exception_q,
   input wire [1:0] overflow_q,
   input wire [1:0] underflow_q,
   input wire [1:0] sof_due_q,
   input wire [1:0] host_irq_q
);
   // one domain, so clock and reset are given once
   default clocking @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   // packet flags follow the lengths sampled with the done pulse
   len_match_a: assert property (
      rx_packet_done[0] |=> length_exception_q[0] ==
         ($past(rx_length_h1) != {1'b0, $past(transfer_count_h1)}))
      else $error("length exception flag wrong");
   ovf_flag_a: assert property (
      rx_packet_done[0] |=> overflow_q[0] ==
         ($past(rx_length_h1) > {1'b0, $past(transfer_count_h1)}))
      else $error("overflow flag wrong");
   unf_flag_a: assert property (
      rx_packet_done[1] |=> underflow_q[1] ==
         ($past(rx_length_h2) < {1'b0, $past(transfer_count_h2)}))
      else $error("underflow flag wrong");
   flag_excl_a: assert property (
      length_exception_q == (overflow_q | underflow_q) && (overflow_q & underflow_q) == 2'b00)
      else $error("length flags inconsistent");
   // register port effects
   target_addr_a: assert property (
      reg_wr && reg_addr == `USBHFE_H1_TARGET_ADDR |=> target_addr_h1_q == $past(reg_wdata[6:0]))
      else $error("target address not taken");
   frame_clear_a: assert property (
      reg_wr && reg_addr == `USBHFE_H1_FRAME_RELOAD ##1
      reg_rd && reg_addr == `USBHFE_H1_NEXT_FRAME |=> reg_rdata_q == 16'h0000)
      else $error("frame number not cleared");
   reload_read_a: assert property (
      reg_wr && reg_addr == `USBHFE_H1_FRAME_RELOAD ##1 reg_rd && reg_addr ==
      `USBHFE_H1_FRAME_RELOAD |=> reg_rdata_q == {2'b00, $past(reg_wdata[13:0], 2)})
      else $error("reload read differs");
   irq_mask_a: assert property (
      reg_wr && reg_addr == `USBHFE_H1_EVENT_ENABLE && reg_wdata == 16'h0000
      |=> ##1 !host_irq_q[0])
      else $error("request not masked");
   // ticks are at least eight core cycles apart
   sof_space_a: assert property (
      sof_due_q[0] |=> !sof_due_q[0] [*7])
      else $error("frame pulses too close");
   sof_space2_a: assert property (
      sof_due_q[1] |=> !sof_due_q[1] [*7])
      else $error("second frame pulses too close");

   cover property (overflow_q[0]);
   cover property (sof_due_q[0]);
   cover property (host_irq_q[1]);
endmodule

bind usbhfe_host_regs usbhfe_chk chk_u (
   .clock, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q,
   .rx_packet_done, .rx_length_h1, .rx_length_h2, .transfer_count_h1,
   .transfer_count_h2, .target_addr_h1_q, .length_exception_q, .overflow_q,
   .underflow_q, .sof_due_q, .host_irq_q
);

// ===== tb/usbhfe_peer_model.sv
/* model of the attached peripheral and port: supply and id levels, line
   state, wakeup, transaction ends, frame starts and received packets.
   assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/10ps
module usbhfe_peer_model (
   input wire clock,
   output logic vbus_above_threshold,
   output logic otg_id_level,
   output logic [1:0] line_single_ended_zero_state,
   output logic [1:0] remote_wake,
   output logic [1:0] transfer_done,
   output logic [1:0] sof_sent,
   output logic [1:0] rx_packet_done,
   output logic [10:0] rx_length_h1,
   output logic [10:0] rx_length_h2
);
   // attached, below threshold and quiet at time zero
   initial begin
      vbus_above_threshold = 1'b0;
      otg_id_level = 1'b1;
      line_single_ended_zero_state = 2'b00;
      remote_wake = 2'b00;
      transfer_done = 2'b00;
      sof_sent = 2'b00;
      rx_packet_done = 2'b00;
      rx_length_h1 = 11'h000;
      rx_length_h2 = 11'h000;
   end

   // one event of a kind: 0 supply, 1 id, 2 wakeup, 3 attach or detach, 4 done
   task automatic ev(input [2:0] k, input i);
      case (k)
         3'd0: vbus_above_threshold <= !vbus_above_threshold;
         3'd1: otg_id_level <= !otg_id_level;
         3'd2: remote_wake[i] <= 1'b1;
         3'd3: line_single_ended_zero_state[i] <= !line_single_ended_zero_state[i];
         default: transfer_done[i] <= 1'b1;
      endcase
      @(posedge clock);
      remote_wake <= 2'b00;
      transfer_done <= 2'b00;
      @(posedge clock);
   endtask

   task automatic sof(input i);
      sof_sent[i] <= 1'b1;
      @(posedge clock);
      sof_sent <= 2'b00;
      @(posedge clock);
   endtask

   // length is only valid with the pulse, so it is scrambled afterwards
   task automatic pkt(input i, input [10:0] n);
      rx_packet_done[i] <= 1'b1;
      if (i)
         rx_length_h2 <= n;
      else
         rx_length_h1 <= n;
      @(posedge clock);
      rx_packet_done <= 2'b00;
      rx_length_h1 <= ~rx_length_h1;
      rx_length_h2 <= ~rx_length_h2;
      @(posedge clock);
   endtask
endmodule

// ===== tb/tb_top.sv
/* self-checking bench of the dual host register block.
   assumes the peer model drives the port events and the bind adds the checker. */
`timescale 1ns/10ps
`include "usbhfe_map.vh"
module tb_top;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic [9:0] transfer_count_h1 = 10'h000;
   logic [9:0] transfer_count_h2 = 10'h000;
   wire [15:0] reg_rdata_q;
   wire reg_rvalid_q, vbus_above_threshold, otg_id_level;
   wire [1:0] line_single_ended_zero_state, remote_wake, transfer_done, sof_sent;
   wire [1:0] rx_packet_done, length_exception_q, overflow_q, underflow_q, sof_due_q, host_irq_q;
   wire [10:0] rx_length_h1, rx_length_h2;
   wire [6:0] target_addr_h1_q, target_addr_h2_q;
   int err_total = 0;
   int samples_checked = 0;
   int n;
   int p;
   logic [15:0] rdv, ex, fl, b;
   logic [10:0] ct [5] = '{11'h00A, 11'h00A, 11'h00A, 11'h000, 11'h3FF};
   logic [10:0] ln [5] = '{11'h00A, 11'h004, 11'h00D, 11'h001, 11'h7FF};
   logic [15:0] em [5] = '{16'h8000, 16'h4000, 16'h0040, 16'h0010, 16'h0001};

   usbhfe_host_regs dut_u (.clock, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata_q, .reg_rvalid_q, .vbus_above_threshold, .otg_id_level,
      .line_single_ended_zero_state, .remote_wake, .transfer_done, .sof_sent,
      .rx_packet_done, .rx_length_h1, .rx_length_h2, .transfer_count_h1,
      .transfer_count_h2, .target_addr_h1_q, .target_addr_h2_q, .length_exception_q,
      .overflow_q, .underflow_q, .sof_due_q, .host_irq_q);
   usbhfe_peer_model peer_u (.clock, .vbus_above_threshold, .otg_id_level,
      .line_single_ended_zero_state, .remote_wake, .transfer_done, .sof_sent,
      .rx_packet_done, .rx_length_h1, .rx_length_h2);

   always #5 clock = !clock;

   task automatic test_done;
      if (err_total == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input [15:0] got, input [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // strobe is left up so a following access changes it only once
   task automatic wr(input [15:0] a, input [15:0] d);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
   endtask

   task automatic idle;
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask

   // read, wait for the answer under a bound, compare the masked word
   task automatic rd(input [15:0] a, input [15:0] m, input [15:0] e);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (reg_rvalid_q !== 1'b1 && n < 8);
      if (reg_rvalid_q !== 1'b1) begin
         err_total++;
         test_done();
      end
      rdv = reg_rdata_q;
      chk(rdv & m, e);
      @(posedge clock);
   endtask

   // cycles up to the next frame pulse land in p
   task automatic wsof(input int lim);
      p = 0;
      do begin
         @(negedge clock);
         p++;
      end while (sof_due_q[0] !== 1'b1 && p < lim);
      if (sof_due_q[0] !== 1'b1) begin
         err_total++;
         test_done();
      end
      @(posedge clock);
   endtask

   initial begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      // values after reset, and an unmapped place
      rd(`USBHFE_H1_FRAME_RELOAD, 16'hFFFF, 16'h2EE0);
      rd(`USBHFE_H2_FRAME_RELOAD, 16'hFFFF, 16'h2EE0);
      rd(`USBHFE_H1_NEXT_FRAME, 16'hFFFF, 16'h0000);
      rd(`USBHFE_H1_EVENT_ENABLE, 16'hFFFF, 16'h0000);
      rd(16'hC0FE, 16'hFFFF, 16'h0000);
      // target addresses of both instances
      wr(`USBHFE_H1_TARGET_ADDR, 16'h005A);
      wr(`USBHFE_H2_TARGET_ADDR, 16'h0023);
      idle();
      chk({9'h0, target_addr_h1_q}, 16'h005A);
      chk({9'h0, target_addr_h2_q}, 16'h0023);
      // exact, short, long and extreme packets on both instances
      for (int i = 0; i < 5; i++) begin
         for (int h = 0; h < 2; h++) begin
            b = h ? 16'h0020 : 16'h0000;
            ex = {5'h0, ct[i]} - {5'h0, ln[i]};
            if (ln[i] > ct[i])
               ex[15:10] = 6'h3F;
            fl = {13'h0, ln[i] != ct[i], ln[i] > ct[i], ln[i] < ct[i]};
            if (h)
               transfer_count_h2 <= ct[i][9:0];
            else
               transfer_count_h1 <= ct[i][9:0];
            peer_u.pkt(h[0], ln[i]);
            rd(`USBHFE_H1_COUNT_DIFF + b, 16'hFFFF, ex);
            chk({13'h0, length_exception_q[h], overflow_q[h], underflow_q[h]}, fl);
         end
      end
      // every event but frame expiry of the first instance: latch, request, keep, clear
      wr(`USBHFE_H1_EVENT_ENABLE, `USBHFE_H1_EVENT_MASK);
      rd(`USBHFE_H1_EVENT_ENABLE, 16'hFFFF, 16'hC251);
      for (int k = 0; k < 5; k++) begin
         peer_u.ev(k[2:0], 1'b0);
         repeat (2) @(posedge clock);
         ex = em[k] | {13'h0, line_single_ended_zero_state[0], 2'b00};
         rd(`USBHFE_H1_EVENT_STATUS, 16'hFFFF, ex);
         chk({15'h0, host_irq_q[0]}, 16'h0001);
         wr(`USBHFE_H1_EVENT_STATUS, 16'h0000);
         rd(`USBHFE_H1_EVENT_STATUS, 16'hFFFF, ex);
         wr(`USBHFE_H1_EVENT_STATUS, em[k]);
         rd(`USBHFE_H1_EVENT_STATUS, 16'hFFFF, ex ^ em[k]);
         chk({15'h0, host_irq_q[0]}, 16'h0000);
      end
      // a flag latches with its enable off, but raises no request
      wr(`USBHFE_H1_EVENT_ENABLE, 16'h0000);
      peer_u.ev(3'd2, 1'b0);
      rd(`USBHFE_H1_EVENT_STATUS, 16'h0040, 16'h0040);
      chk({15'h0, host_irq_q[0]}, 16'h0000);
      // second instance has no supply or id events
      wr(`USBHFE_H2_EVENT_ENABLE, `USBHFE_H2_EVENT_MASK);
      rd(`USBHFE_H2_EVENT_ENABLE, 16'hFFFF, `USBHFE_H2_EVENT_MASK);
      peer_u.ev(3'd0, 1'b1);
      peer_u.ev(3'd1, 1'b1);
      peer_u.ev(3'd4, 1'b1);
      repeat (2) @(posedge clock);
      rd(`USBHFE_H2_EVENT_STATUS, 16'hFFFF, 16'h0001);
      chk({14'h0, host_irq_q}, 16'h0002);
      // frame number counts frame starts and clears on a reload write
      wr(`USBHFE_H1_FRAME_RELOAD, 16'h0010);
      idle();
      repeat (3) peer_u.sof(1'b0);
      rd(`USBHFE_H1_NEXT_FRAME, 16'hFFFF, 16'h0003);
      wr(`USBHFE_H1_NEXT_FRAME, 16'h0005);
      rd(`USBHFE_H1_NEXT_FRAME, 16'hFFFF, 16'h0003);
      wr(`USBHFE_H1_FRAME_RELOAD, 16'h0010);
      rd(`USBHFE_H1_NEXT_FRAME, 16'hFFFF, 16'h0000);
      wr(`USBHFE_H1_FRAME_RELOAD, 16'h0010);
      rd(`USBHFE_H1_FRAME_RELOAD, 16'hFFFF, 16'h0010);
      // live count falls twelve or thirteen over 102 core cycles
      rd(`USBHFE_H2_FRAME_LIVE, 16'hC000, 16'h0000);
      p = rdv;
      repeat (100) @(posedge clock);
      rd(`USBHFE_H2_FRAME_LIVE, 16'hC000, 16'h0000);
      chk({15'h0, (p - rdv) inside {12, 13}}, 16'h0001);
      // the old count runs out first, then frames of 17 ticks follow
      wsof(101000);
      rd(`USBHFE_H1_EVENT_STATUS, 16'h0200, 16'h0200);
      rd(`USBHFE_H2_EVENT_STATUS, 16'h0200, 16'h0200);
      wsof(400);
      wsof(400);
      chk({15'h0, p inside {141, 142}}, 16'h0001);
      test_done();
   end
endmodule
